/* File: core/ccr_pkg.sv */
/*
  Constants for the codec control register bank: addresses, field
  positions, reset values and encodings.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ccr_pkg;
  localparam logic [2:0] ADDR_RSVD_LOW = 3'h0;
  localparam logic [2:0] ADDR_GAIN = 3'h1;
  localparam logic [2:0] ADDR_FILT = 3'h2;
  localparam logic [2:0] ADDR_PWR = 3'h3;
  localparam logic [2:0] ADDR_FAST = 3'h4;
  localparam logic [2:0] ADDR_SLOW = 3'h5;
  localparam logic [7:0] RST_GAIN = 8'h46;
  localparam logic [7:0] RST_FILT = 8'h11;
  localparam logic [7:0] RST_PWR = 8'h00;
  localparam logic [7:0] RST_FAST = 8'hf7;
  localparam logic [7:0] RST_SLOW = 8'h42;
  localparam int WORD_W = 12;
  localparam int RW_BIT = 11;
  localparam int ADDR_HI = 10;
  localparam int ADDR_LO = 8;
  localparam int READBACK_BIT = 7;
  localparam int WEAK_BIT = 7;
  localparam int HPF_HI = 6;
  localparam int HPF_LO = 5;
  localparam int SHIFT_HI = 4;
  localparam int SHIFT_LO = 2;
  localparam int DACM_HI = 1;
  localparam int DACM_LO = 0;
  localparam int ADAPT_BIT = 7;
  localparam int BRIDGE_EN_BIT = 6;
  localparam int BRIDGE_DRV_BIT = 5;
  localparam int HYST_BIT = 4;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 2;
  localparam int MIC_PD_BIT = 1;
  localparam int FRONT_PD_BIT = 0;
  localparam logic [6:0] GAIN_MAX = 7'h52;
  localparam logic [1:0] HPF_UNUSED = 2'h3;
  localparam logic [2:0] SHIFT_MAX = 3'h5;
  localparam logic [2:0] SHIFT_NONE = 3'h0;
  localparam int ADC_W = 16;
  localparam int DAC_W = 20;
  // Frames of the control word exchange
  localparam logic [1:0] FRAMES_PER_ACCESS = 2'h2;
  typedef enum logic [1:0]
  {
    DAC_OFF = 2'b00,
    DAC_SHIFTED = 2'b01,
    DAC_DIRECT = 2'b10,
    DAC_LOOP = 2'b11
  } ccr_dac_mode_t;
  typedef enum logic [1:0]
  {
    GM_AUTO_DUAL = 2'b00,
    GM_AUTO_SINGLE = 2'b01,
    GM_FIXED_SINGLE = 2'b10,
    GM_FIXED_NOW = 2'b11
  } ccr_gain_mode_t;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_DONE = 2'b10
  } ccr_state_t;
endpackage

/* File: core/ccr_word_decode.sv */
/*
  Splits a 12-bit control word into direction, address and data and
  flags whether it targets a live register.
  Assumes the word is stable while word_valid is high.
*/
`timescale 1ns/1ns
module ccr_word_decode
  import ccr_pkg::*;
(
  // Control word
  input wire logic [WORD_W-1:0] word,
  input wire logic word_valid,
  // Decoded fields
  output logic is_write,
  output logic [2:0] addr,
  output logic [7:0] data,
  output logic active,
  output logic mapped
);
  assign is_write = word[RW_BIT];
  assign addr = word[ADDR_HI:ADDR_LO];
  assign data = word[7:0];
  // Zero address means no control this frame
  assign active = word_valid && (addr != ADDR_RSVD_LOW); // RL17
  assign mapped = (addr >= ADDR_GAIN) && (addr <= ADDR_SLOW); // RL1
endmodule // ccr_word_decode

/* File: core/ccr_rate_select.sv */
/*
  Picks the attack and release rate codes the gain engine uses.
  Assumes both rate registers are already held in flip-flops.
*/
`timescale 1ns/1ns
module ccr_rate_select
  import ccr_pkg::*;
(
  // Registers
  input wire logic [7:0] fast_rate,
  input wire logic [7:0] slow_rate,
  input wire logic [1:0] mode,
  // Selected codes
  output logic [3:0] fast_attack,
  output logic [3:0] fast_release,
  output logic [3:0] slow_attack,
  output logic [3:0] slow_release,
  output logic slow_active
);
  assign fast_attack = fast_rate[7:4]; // RL13
  assign fast_release = fast_rate[3:0]; // RL14
  // Slow pair only matters in dual-rate automatic mode
  assign slow_active = (mode == GM_AUTO_DUAL); // RL15
  assign slow_attack = slow_active ? slow_rate[7:4] : fast_rate[7:4]; // RL15
  assign slow_release = slow_active ? slow_rate[3:0] : fast_rate[3:0]; // RL14
endmodule // ccr_rate_select

/* File: core/ccr_regs.sv */
/*
  Control register bank of the voice codec. Holds five 8-bit registers
  written and read through 12-bit control words carried by the serial
  frame logic, and drives the decoded controls to the front end,
  filters, shifter, DAC and output driver.
  Assumes the frame logic presents one control word per frame with a
  one-cycle frame_strobe, and that the gain engine reports the gain
  it currently applies.
*/
// Operation
// RL1 - Addresses one to five select the registers
// RL2 - Processor never writes reserved addresses
// RL3 - Gain bit seven picks stored or applied
// RL4 - Gain code: half-dB steps, -1 to +40
// RL5 - Filter bit seven selects weak I/O drive
// RL6 - Highpass field: normal, bypass, 100 Hz
// RL7 - Shift field shifts ADC word 0..5 bits
// RL8 - DAC select: off, shifted, direct, loopback
// RL9 - Power bit seven selects adaptive quantization
// RL10 - Bridge enable and 40/20 ohm drive
// RL11 - Hysteresis timeout 50 or 25 ms
// RL12 - Gain mode field picks four behaviours
// RL13 - Fast upper nibble selects attack rate
// RL14 - Lower nibbles select release rate
// RL15 - Slow rates apply in dual-rate mode only
// RL16 - Power bits shut mic supply, front end
// RL17 - Twelve-bit word: rw, address, data
// RL18 - Unused bits always read as zero
// RL19 - Each register access spans two frames
`timescale 1ns/1ns
module ccr_regs
  import ccr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Control word from the serial frame logic
  input wire logic frame_strobe,
  input wire logic [WORD_W-1:0] control_word,
  // Read answer back into the next frame
  output logic [7:0] read_data,
  output logic read_valid,
  output logic access_busy,
  // Gain engine
  input wire logic [6:0] applied_gain,
  output logic [6:0] gain_code,
  output logic [1:0] gain_control_mode,
  output logic hysteresis_timeout_select,
  output logic [3:0] attack_fast,
  output logic [3:0] release_fast,
  output logic [3:0] attack_slow,
  output logic [3:0] release_slow,
  output logic slow_rates_used,
  // Filters, shifter and DAC
  output logic weak_io_drive,
  output logic [1:0] highpass_select,
  output logic [2:0] shift_amount,
  output logic [1:0] dac_input_mode,
  output logic dac_adaptive_quant,
  // Output driver and power
  output logic bridge_output_enable,
  output logic bridge_drive_strength,
  output logic mic_supply_powerdown,
  output logic input_path_powerdown
);
  logic [7:0] gain_setting;
  logic [7:0] filter_shift_control;
  logic [7:0] power_output_control;
  logic [7:0] fast_rate_control;
  logic [7:0] slow_rate_control;
  ccr_state_t state;
  ccr_state_t next_state;
  logic [WORD_W-1:0] held_word;
  logic dec_write;
  logic [2:0] dec_addr;
  logic [7:0] dec_data;
  logic dec_active;
  logic dec_mapped;
  logic start;
  logic finish;
  logic do_write;
  logic [7:0] read_mux;
  logic [7:0] gain_view;
  logic [2:0] shift_eff;
  logic [3:0] sel_fa;
  logic [3:0] sel_fr;
  logic [3:0] sel_sa;
  logic [3:0] sel_sr;
  logic sel_slow;
  logic [1:0] next_highpass;
  logic [2:0] next_shift;

  function automatic logic [6:0] clamp_gain(input logic [6:0] g);
    clamp_gain = (g > GAIN_MAX) ? GAIN_MAX : g;
  endfunction

  ccr_word_decode u_dec
  (
    .word(held_word),
    .word_valid(state == ST_HOLD),
    .is_write(dec_write),
    .addr(dec_addr),
    .data(dec_data),
    .active(dec_active),
    .mapped(dec_mapped)
  );

  ccr_rate_select u_rate
  (
    .fast_rate(fast_rate_control),
    .slow_rate(slow_rate_control),
    .mode(power_output_control[MODE_HI:MODE_LO]),
    .fast_attack(sel_fa),
    .fast_release(sel_fr),
    .slow_attack(sel_sa),
    .slow_release(sel_sr),
    .slow_active(sel_slow)
  );

  // First frame latches the word, second frame completes it
  assign start = frame_strobe && (state == ST_IDLE) &&
    (control_word[ADDR_HI:ADDR_LO] != ADDR_RSVD_LOW); // RL17
  assign finish = frame_strobe && (state == ST_HOLD); // RL19
  // Reserved writes are dropped; nothing lives there anyway
  assign do_write = finish && dec_active && dec_write && dec_mapped; // RL1

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (start)
          next_state = ST_HOLD;
      ST_HOLD:
        if (finish)
          next_state = ST_DONE;
      ST_DONE:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Stored contents or live gain, selected by bit seven
  assign gain_view = gain_setting[READBACK_BIT] ?
    {1'b1, clamp_gain(applied_gain)} : gain_setting; // RL3

  assign read_mux =
    (dec_addr == ADDR_GAIN) ? gain_view :
    (dec_addr == ADDR_FILT) ? filter_shift_control :
    (dec_addr == ADDR_PWR) ? power_output_control :
    (dec_addr == ADDR_FAST) ? fast_rate_control :
    (dec_addr == ADDR_SLOW) ? slow_rate_control :
    8'h00; // RL18

  // Codes 11X behave as the largest shift
  assign shift_eff = (filter_shift_control[SHIFT_HI:SHIFT_LO] > SHIFT_MAX) ?
    SHIFT_MAX : filter_shift_control[SHIFT_HI:SHIFT_LO]; // RL7

  // Unused code falls back to normal filtering
  assign next_highpass =
    (filter_shift_control[HPF_HI:HPF_LO] == HPF_UNUSED) ?
    2'h0 : filter_shift_control[HPF_HI:HPF_LO]; // RL6
  // Shift is meaningless unless the shifter path is in use
  assign next_shift =
    (filter_shift_control[DACM_HI:DACM_LO] == DAC_SHIFTED) ?
    shift_eff : SHIFT_NONE; // RL7

  // Word is latched once; the second frame only completes it
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      held_word <= '0;
    end
    else
    begin
      state <= next_state;
      if (start)
        held_word <= control_word;
    end
  end

  // Only mapped addresses reach the write decode
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      gain_setting <= RST_GAIN;
      filter_shift_control <= RST_FILT;
      power_output_control <= RST_PWR;
      fast_rate_control <= RST_FAST;
      slow_rate_control <= RST_SLOW;
    end
    else if (do_write)
    begin
      unique case (dec_addr) // RL1
        ADDR_GAIN: gain_setting <= dec_data;
        ADDR_FILT: filter_shift_control <= dec_data;
        ADDR_PWR: power_output_control <= dec_data;
        ADDR_FAST: fast_rate_control <= dec_data;
        default: slow_rate_control <= dec_data;
      endcase
    end
  end

  // Read answer lands one edge after the second frame
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      read_data <= 8'h00;
      read_valid <= 1'b0;
      access_busy <= 1'b0;
    end
    else
    begin
      read_valid <= finish && dec_active && !dec_write;
      if (finish && dec_active && !dec_write)
        read_data <= read_mux;
      access_busy <= (next_state == ST_HOLD); // RL19
    end
  end

  // Gain engine controls, registered so every output is a flip-flop
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      gain_code <= RST_GAIN[6:0];
      gain_control_mode <= RST_PWR[MODE_HI:MODE_LO];
      hysteresis_timeout_select <= RST_PWR[HYST_BIT];
    end
    else
    begin
      gain_code <= clamp_gain(gain_setting[6:0]); // RL4
      gain_control_mode <= power_output_control[MODE_HI:MODE_LO]; // RL12
      hysteresis_timeout_select <= power_output_control[HYST_BIT]; // RL11
    end
  end

  // Rate codes; slow pair mirrors fast outside dual-rate mode
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      attack_fast <= RST_FAST[7:4];
      release_fast <= RST_FAST[3:0];
      attack_slow <= RST_SLOW[7:4];
      release_slow <= RST_SLOW[3:0];
      slow_rates_used <= (RST_PWR[MODE_HI:MODE_LO] == GM_AUTO_DUAL);
    end
    else
    begin
      attack_fast <= sel_fa; // RL13
      release_fast <= sel_fr; // RL14
      attack_slow <= sel_sa; // RL15
      release_slow <= sel_sr; // RL15
      slow_rates_used <= sel_slow; // RL15
    end
  end

  // Filter, shifter and DAC controls
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      weak_io_drive <= RST_FILT[WEAK_BIT];
      highpass_select <= RST_FILT[HPF_HI:HPF_LO];
      shift_amount <= RST_FILT[SHIFT_HI:SHIFT_LO];
      dac_input_mode <= RST_FILT[DACM_HI:DACM_LO];
    end
    else
    begin
      weak_io_drive <= filter_shift_control[WEAK_BIT]; // RL5
      highpass_select <= next_highpass; // RL6
      shift_amount <= next_shift; // RL7
      dac_input_mode <= filter_shift_control[DACM_HI:DACM_LO]; // RL8
    end
  end

  // DAC quantization, output driver and power-down controls
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      dac_adaptive_quant <= RST_PWR[ADAPT_BIT];
      bridge_output_enable <= RST_PWR[BRIDGE_EN_BIT];
      bridge_drive_strength <= RST_PWR[BRIDGE_DRV_BIT];
      mic_supply_powerdown <= RST_PWR[MIC_PD_BIT];
      input_path_powerdown <= RST_PWR[FRONT_PD_BIT];
    end
    else
    begin
      dac_adaptive_quant <= power_output_control[ADAPT_BIT]; // RL9
      bridge_output_enable <= power_output_control[BRIDGE_EN_BIT]; // RL10
      bridge_drive_strength <= power_output_control[BRIDGE_DRV_BIT]; // RL10
      mic_supply_powerdown <= power_output_control[MIC_PD_BIT]; // RL16
      input_path_powerdown <= power_output_control[FRONT_PD_BIT]; // RL16
    end
  end
endmodule // ccr_regs

/* File: bench/ccr_regs_asserts.sv */
/*
  Port checker for the codec control register bank.
  Assumes it is bound into ccr_regs with the same port names.
*/
`timescale 1ns/1ns
module ccr_regs_chk
  import ccr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Control traffic
  input wire logic frame_strobe,
  input wire logic [WORD_W-1:0] control_word,
  input wire logic read_valid,
  input wire logic access_busy,
  // Decoded controls
  input wire logic [6:0] gain_code,
  input wire logic [1:0] highpass_select,
  input wire logic [2:0] shift_amount,
  input wire logic [1:0] gain_control_mode,
  input wire logic [3:0] attack_fast,
  input wire logic [3:0] release_fast,
  input wire logic [3:0] attack_slow,
  input wire logic [3:0] release_slow,
  input wire logic slow_rates_used
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  wire logic [2:0] word_addr = control_word[ADDR_HI:ADDR_LO];
  // Past busy excludes the ignored cycle right after completion
  sequence idle_strobe_s;
    frame_strobe && !access_busy && !$past(access_busy);
  endsequence
  sequence second_strobe_s;
    frame_strobe && access_busy;
  endsequence
  first_frame_a: assert property (idle_strobe_s ##0 word_addr != 3'h0
    |=> access_busy) else $error("first frame not taken");
  zero_addr_a: assert property (idle_strobe_s ##0 word_addr == 3'h0
    |=> !access_busy) else $error("zero address taken");
  busy_end_a: assert property (second_strobe_s |=> !access_busy)
    else $error("access not closed");
  busy_hold_a: assert property (access_busy && !frame_strobe
    |=> access_busy) else $error("busy dropped early");
  read_cause_a: assert property (read_valid |-> $past(frame_strobe)
    && $past(access_busy)) else $error("read answer uncaused");
  gain_clamp_a: assert property (gain_code <= GAIN_MAX)
    else $error("gain above range");
  hpf_code_a: assert property (highpass_select != HPF_UNUSED)
    else $error("unused highpass code");
  shift_max_a: assert property (shift_amount <= SHIFT_MAX)
    else $error("shift above five");
  slow_mode_a: assert property (slow_rates_used ==
    (gain_control_mode == 2'h0)) else $error("slow select wrong");
  slow_share_a: assert property (!slow_rates_used |->
    attack_slow == attack_fast && release_slow == release_fast)
    else $error("slow rates leaked");
endmodule // ccr_regs_chk

bind ccr_regs ccr_regs_chk chk_u (.*);

/* File: bench/ccr_frame_src.sv */
/*
  Behavioural frame source standing in for the controlling processor.
  Assumes start is raised for one cycle while busy is low.
*/
`timescale 1ns/1ns
module ccr_frame_src
(
  // Clock
  input wire logic mclk,
  // Request from the bench
  input wire logic start,
  input wire logic [11:0] word,
  input wire logic [3:0] gap,
  // Toward the register bank
  output logic frame_strobe,
  output logic [11:0] control_word,
  output logic busy
);
  initial
  begin
    frame_strobe = 1'b0;
    control_word = 12'h0;
    busy = 1'b0;
    forever
    begin
      @(posedge mclk iff start);
      @(negedge mclk);
      busy = 1'b1;
      frame_strobe = 1'b1;
      control_word = word;
      @(negedge mclk);
      frame_strobe = 1'b0;
      // Junk data, zero address: never a second request of its own
      control_word = {4'h0, ~word[7:0]};
      repeat (gap) @(negedge mclk);
      frame_strobe = 1'b1;
      @(negedge mclk);
      frame_strobe = 1'b0;
      repeat (2) @(negedge mclk);
      busy = 1'b0;
    end
  end
endmodule // ccr_frame_src

/* File: bench/ccr_regs_test.sv */
/*
  Self-checking bench for the codec control register bank.
  Assumes the frame source model carries every control word.
*/
`timescale 1ns/1ns
module ccr_regs_test import ccr_pkg::*;;
  logic mclk, reset_n, frame_strobe, read_valid, access_busy, start;
  logic [11:0] control_word, word;
  logic [7:0] read_data;
  logic [6:0] applied_gain, gain_code;
  logic [1:0] gain_control_mode, highpass_select, dac_input_mode;
  logic hysteresis_timeout_select, slow_rates_used, weak_io_drive;
  logic dac_adaptive_quant, bridge_output_enable, bridge_drive_strength;
  logic mic_supply_powerdown, input_path_powerdown, src_busy;
  logic [3:0] attack_fast, release_fast, attack_slow, release_slow, gap;
  logic [2:0] shift_amount;
  int n_fail, num_checks;
  int n_rv = 0;
  wire logic [7:0] pwr_bits = {dac_adaptive_quant, bridge_output_enable,
    bridge_drive_strength, hysteresis_timeout_select, gain_control_mode,
    mic_supply_powerdown, input_path_powerdown};
  wire logic [7:0] rates = {attack_slow, release_slow};
  ccr_frame_src src_u (.mclk(mclk), .start(start), .word(word), .gap(gap),
    .frame_strobe(frame_strobe), .control_word(control_word),
    .busy(src_busy));
  ccr_regs dut_u (.*);
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (read_valid === 1'b1)
      n_rv <= n_rv + 1;
  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(logic w, logic [2:0] a, logic [7:0] d, logic [3:0] g);
    int k;
    @(negedge mclk);
    word = {w, a, d};
    gap = g;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    @(negedge mclk);
    for (k = 0; k < 40 && src_busy !== 1'b0; k++)
      @(negedge mclk);
    if (k == 40)
    begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    acc(1'b1, a, d, 4'h1);
  endtask
  // Slow second frame on reads; data bits of a read word are noise
  task automatic rd(logic [2:0] a, logic [7:0] exp, string nm);
    int c;
    c = n_rv;
    acc(1'b0, a, 8'h5a, 4'h4);
    chk(nm, read_data, exp);
    chk("read pulses", 8'(n_rv - c), 8'h01);
  endtask
  task automatic do_reset;
    reset_n = 1'b0;
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
  endtask
  task automatic t_reset;
    chk("gain code", {1'b0, gain_code}, {1'b0, RST_GAIN[6:0]});
    chk("dac mode", {6'h0, dac_input_mode}, 8'h01);
    chk("shift", {5'h0, shift_amount}, 8'h04);
    chk("slow rates", rates, RST_SLOW);
    rd(ADDR_GAIN, RST_GAIN, "gain reg");
    rd(ADDR_FILT, RST_FILT, "filter reg");
    rd(ADDR_PWR, RST_PWR, "power reg");
    rd(ADDR_FAST, RST_FAST, "fast reg");
    rd(ADDR_SLOW, RST_SLOW, "slow reg");
    $display("test reset done");
  endtask
  task automatic t_fields;
    int m;
    logic [7:0] e;
    wr(ADDR_FILT, 8'hd9);
    wr(ADDR_PWR, 8'hf6);
    wr(ADDR_FAST, 8'h5a);
    wr(ADDR_SLOW, 8'h3c);
    wr(ADDR_GAIN, 8'h7f);
    chk("weak drive", {7'h0, weak_io_drive}, 8'h01);
    chk("highpass", {6'h0, highpass_select}, 8'h02);
    chk("power bits", pwr_bits, 8'hf6);
    chk("fast rates", {attack_fast, release_fast}, 8'h5a);
    chk("gain clamp", {1'b0, gain_code}, {1'b0, GAIN_MAX});
    rd(ADDR_GAIN, 8'h7f, "gain stored");
    rd(ADDR_FILT, 8'hd9, "filter reg");
    for (m = 0; m < 4; m++)
    begin
      wr(ADDR_PWR, 8'(m << 2));
      e = (m == 0) ? 8'h3c : 8'h5a;
      chk("gain mode", {6'h0, gain_control_mode}, 8'(m));
      chk("slow pick", rates, e);
      chk("slow used", {7'h0, slow_rates_used}, 8'(m == 0));
      wr(ADDR_FILT, 8'(8'h10 | m));
      chk("dac mode", {6'h0, dac_input_mode}, 8'(m));
      chk("dac shift", {5'h0, shift_amount}, 8'(m == 1) << 2);
    end
    for (m = 0; m < 8; m++)
    begin
      wr(ADDR_FILT, 8'((m % 4) << 5 | m << 2 | 1));
      e = (m % 4 == 3) ? 8'h00 : 8'(m % 4);
      chk("shift", {5'h0, shift_amount}, (m > 5) ? 8'h05 : 8'(m));
      chk("highpass", {6'h0, highpass_select}, e);
    end
    $display("test fields done");
  endtask
  task automatic t_gain_read;
    applied_gain = 7'h2a;
    wr(ADDR_GAIN, 8'h85);
    chk("gain code", {1'b0, gain_code}, 8'h05);
    rd(ADDR_GAIN, 8'haa, "applied gain");
    $display("test gain read done");
  endtask
  task automatic t_reserved;
    int c;
    c = n_rv;
    // Zero address carries no control, so no answer comes back
    acc(1'b0, ADDR_RSVD_LOW, 8'hff, 4'h1);
    chk("zero addr pulses", 8'(n_rv - c), 8'h00);
    rd(3'h6, 8'h00, "reserved six");
    rd(3'h7, 8'h00, "reserved seven");
    rd(ADDR_GAIN, 8'haa, "gain kept");
    chk("gain code", {1'b0, gain_code}, 8'h05);
    $display("test reserved done");
  endtask
  initial
  begin
    start = 1'b0;
    word = 12'h0;
    gap = 4'h1;
    applied_gain = 7'h0;
    n_fail = 0;
    num_checks = 0;
    do_reset();
    t_reset();
    t_fields();
    t_gain_read();
    t_reserved();
    // Mid-run reset must restore every default
    do_reset();
    t_reset();
    report_and_stop();
  end
endmodule // ccr_regs_test
